//--- verilog/drive_gen_pkg.sv
// constants and carrier types for the bunch drive generator
package drive_gen_pkg;
  // timing
  localparam int         CLK_PERIOD_NS  = 4;
  localparam int         NS_PER_US      = 1000;
  localparam logic [7:0] CYC_PER_US     = 8'(NS_PER_US / CLK_PERIOD_NS);
  // structure
  localparam int         PHASE_W        = 30;
  localparam int         BUNCHES        = 64;
  localparam int         FIFO_DEPTH     = 16;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF       = 8'h00;
  localparam logic [7:0] AMPL_OFF       = 8'h04;
  localparam logic [7:0] FREQ_OFF       = 8'h08;
  localparam logic [7:0] SPAN_OFF       = 8'h0c;
  localparam logic [7:0] PERIOD_OFF     = 8'h10;
  localparam logic [7:0] MASK_LO_OFF    = 8'h14;
  localparam logic [7:0] MASK_HI_OFF    = 8'h18;
  localparam logic [7:0] LAST_OFF       = 8'h1c;
  localparam logic [7:0] ACT_FREQ_OFF   = 8'h20;
  localparam logic [7:0] ACT_SPAN_OFF   = 8'h24;
  localparam logic [7:0] ACT_PERIOD_OFF = 8'h28;
  localparam logic [7:0] STATUS_OFF     = 8'h2c;
  // field positions
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_WAVE_LSB  = 1;
  // reset values and scale
  localparam logic [16:0] AMPL_RST      = 17'h00000;
  localparam logic [16:0] AMPL_FULL     = 17'h10000;
  localparam logic [29:0] FREQ_RST      = 30'h00000000;
  localparam logic [23:0] SPAN_RST      = 24'h000000;
  localparam logic [15:0] PERIOD_RST    = 16'h0000;
  localparam logic [63:0] MASK_RST      = 64'h0000000000000000;
  localparam logic [5:0]  LAST_RST      = 6'h3f;

  typedef enum logic [1:0] {
    WAVE_SINE,
    WAVE_SQUARE,
    WAVE_DC
  } wave_t;

  typedef struct packed {
    logic [5:0]          bunch;
    logic signed [15:0]  val;
  } drive_sample_t;
endpackage

//--- verilog/drive_fifo.sv
// sample fifo with registered read port
`timescale 1ns/1ns
module drive_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
    logic [WIDTH-1:0]            dout;
    logic                        ov;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t n;
  logic        empty;
  logic        full;

  always_comb begin
    n     = r;
    empty = (r.wp == r.rp);
    full  = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    if (out_ready_i) begin
      n.ov = 1'b0;
    end
    // refill the output register whenever it is free or being taken
    if (!empty && (!r.ov || out_ready_i)) begin
      n.dout = r.mem[r.rp[AW-1:0]];
      n.ov   = 1'b1;
      n.rp   = r.rp + 1'b1;
    end
    if (in_valid_i && !full) begin
      n.mem[r.wp[AW-1:0]] = in_data_i;
      n.wp                = r.wp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_ready_o  = !full;
  assign out_data_o  = r.dout;
  assign out_valid_o = r.ov;
endmodule // drive_fifo

//--- verilog/bunch_drive_gen.sv
// bunch-by-bunch drive generator with apb registers
//
// Overview of operation
// - excitation value computed separately per bunch slot
// - output scaled by amplitude zero to one
// - frequency step is rf clock over 2^30
// - waveform select: sine, square or dc
// - sweep only in sine and square shapes
// - span of zero disables sweep
// - period of zero disables sweep
// - bunches outside enable pattern get no drive
// - frequency in use readable by host
// - applied span and period readable by host
// - drive mask written directly and read back
`timescale 1ns/1ns
module bunch_drive_gen
  import drive_gen_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // revolution fiducial pin
  input  wire logic        fid_i,
  // dac sample stream
  output drive_sample_t    dac_o,
  output logic             dac_valid_o,
  input  wire logic        dac_ready_i
);
  typedef struct packed {
    logic          en;
    wave_t         wave;
    logic [16:0]   ampl;
    logic [29:0]   freq;
    logic [23:0]   span;
    logic [15:0]   period;
    logic [63:0]   mask;
    logic [5:0]    last;
    logic [29:0]   phase;
    logic [5:0]    bunch;
    logic [23:0]   off;
    logic [24:0]   err;
    logic [23:0]   pcnt;
    logic          fid_s1;
    logic          fid_s2;
    logic          fid_prev;
    logic [31:0]   prdata;
  } gen_state_t;

  gen_state_t          r;
  gen_state_t          n;
  logic [23:0]         period_cyc;
  logic                mod_on;
  logic [23:0]         act_span;
  logic [29:0]         freq_use;
  logic                advance;
  logic                fid_edge;
  logic                fifo_in_ready;
  logic signed [15:0]  wave_val;
  logic [9:0]          para_x;
  logic [19:0]         para_y;
  logic signed [33:0]  prod;
  logic [24:0]         err_sum;
  drive_sample_t       smp;
  logic                wr_acc;
  logic                addr_hit;
  logic [31:0]         rd_mux;
  logic [16:0]         ampl_wr;

  always_comb begin
    n          = r;
    period_cyc = {8'h00, r.period} * {16'h0000, CYC_PER_US};
    mod_on     = (r.span != 24'h0) && (r.period != 16'h0)
                 && (r.wave != WAVE_DC);
    // span is capped: the offset can climb at most one step per clock
    act_span   = mod_on ? ((r.span > period_cyc) ? period_cyc : r.span) : 24'h0;
    freq_use   = mod_on ? (r.freq - {7'h00, act_span[23:1]} + {6'h00, r.off}) : r.freq;
    advance    = r.en && fifo_in_ready;
    fid_edge   = r.fid_s2 && !r.fid_prev;
    err_sum    = r.err + {1'b0, r.span};

    // parabolic half-wave keeps the shape table out of the fabric
    para_x = r.phase[28:19];
    para_y = {10'h000, para_x} * {10'h000, 10'h3ff - para_x};
    case (r.wave)
      WAVE_SINE: begin
        wave_val = $signed({1'b0, para_y[17:3]});
        if (r.phase[29]) begin
          wave_val = -wave_val;
        end
      end
      WAVE_SQUARE: begin
        wave_val = r.phase[29] ? 16'sh8001 : 16'sh7fff;
      end
      WAVE_DC: begin
        wave_val = 16'sh7fff;
      end
      default: begin
        wave_val = 16'sh0000;
      end
    endcase
    prod      = wave_val * $signed({1'b0, r.ampl});
    smp.bunch = r.bunch;
    smp.val   = r.mask[r.bunch] ? prod[31:16] : 16'sh0000;

    // generator advances only when the fifo can take the sample
    if (advance) begin
      n.phase = r.phase + freq_use;
      n.bunch = (r.bunch == r.last) ? 6'h00 : r.bunch + 6'h01;
    end
    // ramp state drops at once when sweep is off, so no stale offset lingers
    if (!mod_on) begin
      n.pcnt = 24'h0;
      n.off  = 24'h0;
      n.err  = 25'h0;
    end else if (advance) begin
      if (r.pcnt + 24'h000001 >= period_cyc) begin
        n.pcnt = 24'h0;
        n.off  = 24'h0;
        n.err  = 25'h0;
      end else begin
        n.pcnt = r.pcnt + 24'h000001;
        if (err_sum >= {1'b0, period_cyc}) begin
          n.err = err_sum - {1'b0, period_cyc};
          n.off = r.off + 24'h000001;
        end else begin
          n.err = err_sum;
        end
      end
    end
    if (fid_edge) begin
      n.bunch = 6'h00;
    end
    n.fid_s1   = fid_i;
    n.fid_s2   = r.fid_s1;
    n.fid_prev = r.fid_s2;

    // apb decode
    addr_hit = 1'b1;
    case (paddr_i)
      CTRL_OFF:       rd_mux = {29'h0, r.wave, r.en};
      AMPL_OFF:       rd_mux = {15'h0, r.ampl};
      FREQ_OFF:       rd_mux = {2'h0, r.freq};
      SPAN_OFF:       rd_mux = {8'h0, r.span};
      PERIOD_OFF:     rd_mux = {16'h0, r.period};
      MASK_LO_OFF:    rd_mux = r.mask[31:0];
      MASK_HI_OFF:    rd_mux = r.mask[63:32];
      LAST_OFF:       rd_mux = {26'h0, r.last};
      ACT_FREQ_OFF:   rd_mux = {2'h0, freq_use};
      ACT_SPAN_OFF:   rd_mux = {8'h0, act_span};
      ACT_PERIOD_OFF: rd_mux = mod_on ? {16'h0, r.period} : 32'h0;
      STATUS_OFF:     rd_mux = {24'h0, !fifo_in_ready, mod_on, r.bunch};
      default: begin
        rd_mux   = 32'h0;
        addr_hit = 1'b0;
      end
    endcase
    // read data is captured in the setup cycle so the access needs no wait
    if (psel_i && !penable_i) begin
      n.prdata = rd_mux;
    end
    wr_acc  = psel_i && penable_i && pwrite_i;
    ampl_wr = (pwdata_i[16:0] > AMPL_FULL) ? AMPL_FULL : pwdata_i[16:0];
    if (wr_acc) begin
      case (paddr_i)
        CTRL_OFF: begin
          n.en   = pwdata_i[CTRL_EN_BIT];
          n.wave = wave_t'(pwdata_i[CTRL_WAVE_LSB +: 2]);
        end
        AMPL_OFF:    n.ampl   = ampl_wr;
        FREQ_OFF:    n.freq   = pwdata_i[29:0];
        SPAN_OFF:    n.span   = pwdata_i[23:0];
        PERIOD_OFF:  n.period = pwdata_i[15:0];
        MASK_LO_OFF: n.mask[31:0]  = pwdata_i;
        MASK_HI_OFF: n.mask[63:32] = pwdata_i;
        LAST_OFF:    n.last   = pwdata_i[5:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r        <= '0;
      r.wave   <= WAVE_SINE;
      r.ampl   <= AMPL_RST;
      r.freq   <= FREQ_RST;
      r.span   <= SPAN_RST;
      r.period <= PERIOD_RST;
      r.mask   <= MASK_RST;
      r.last   <= LAST_RST;
    end else begin
      r <= n;
    end
  end

  drive_fifo #(
    .WIDTH ($bits(drive_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (smp),
    .in_valid_i  (r.en),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (dac_o),
    .out_valid_o (dac_valid_o),
    .out_ready_i (dac_ready_i)
  );

  assign prdata_o  = r.prdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  property p_masked_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      advance && !r.mask[r.bunch] |-> smp.val == 16'sh0000;
  endproperty
  a_masked_zero: assert property (p_masked_zero) else $error("masked bunch driven");

  property p_span_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      r.span == 24'h0 |-> freq_use == r.freq;
  endproperty
  a_span_off: assert property (p_span_off) else $error("sweep with zero span");

  property p_period_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      r.period == 16'h0 |-> freq_use == r.freq ##1 r.off == 24'h0;
  endproperty
  a_period_off: assert property (p_period_off) else $error("sweep with zero period");

  property p_dc_fixed;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      r.wave == WAVE_DC && advance |-> !mod_on && freq_use == r.freq;
  endproperty
  a_dc_fixed: assert property (p_dc_fixed) else $error("dc shape swept");

  property p_dc_level;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      advance && r.wave == WAVE_DC && r.mask[r.bunch] && r.ampl == AMPL_FULL |-> smp.val == 16'sh7fff;
  endproperty
  a_dc_level: assert property (p_dc_level) else $error("dc level wrong at full scale");

  property p_fid_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      fid_edge |=> r.bunch == 6'h00;
  endproperty
  a_fid_zero: assert property (p_fid_zero) else $error("fiducial did not realign");

  property p_phase_step;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      advance |=> r.phase == 30'($past(r.phase) + $past(freq_use));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

  property p_zero_ampl;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      r.ampl == 17'h0 |-> smp.val == 16'sh0000;
  endproperty
  a_zero_ampl: assert property (p_zero_ampl) else $error("zero amplitude nonzero out");

  property p_bunch_step;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      advance && !fid_edge && r.bunch != r.last |=> r.bunch == $past(r.bunch) + 6'h01;
  endproperty
  a_bunch_step: assert property (p_bunch_step) else $error("bunch slot skipped");

  property p_mask_rb;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_acc && paddr_i == MASK_LO_OFF |=> r.mask[31:0] == $past(pwdata_i);
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask not stored");

  property p_act_freq;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      psel_i && !penable_i && paddr_i == ACT_FREQ_OFF |=> prdata_o == {2'h0, $past(freq_use)};
  endproperty
  a_act_freq: assert property (p_act_freq) else $error("actual frequency readback wrong");

  property p_act_span;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mod_on |-> act_span <= r.span && act_span <= period_cyc;
  endproperty
  a_act_span: assert property (p_act_span) else $error("applied span out of range");

  property p_ramp_wrap;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      advance && mod_on && r.pcnt + 24'h000001 >= period_cyc |=> r.off == 24'h0 && r.pcnt == 24'h0;
  endproperty
  a_ramp_wrap: assert property (p_ramp_wrap) else $error("ramp did not restart");

  c_sweep_wrap: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    advance && mod_on && r.off != 24'h0 ##1 r.off == 24'h0);
  c_square_out: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    advance && r.wave == WAVE_SQUARE && smp.val != 16'sh0000);
  c_fifo_stall: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    r.en && !fifo_in_ready);
  c_fid_realign: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fid_edge && r.bunch != 6'h00);
endmodule // bunch_drive_gen

//--- test/dac_sink.sv
// behavioural dac output path that records every sample it takes
`timescale 1ns/1ns
module dac_sink
  import drive_gen_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_b_i,
  // sample stream
  input  wire drive_sample_t dac_i,
  input  wire logic          dac_valid_i,
  output logic               dac_ready_o,
  // bench control
  input  wire logic          stall_i
);
  drive_sample_t got_q[$];

  // a stalled path refuses outright, so the generator must back up
  assign dac_ready_o = !stall_i;

  always @(posedge ref_clk_i) begin
    if (rst_b_i && dac_valid_i && dac_ready_o) begin
      got_q.push_back(dac_i);
    end
  end
endmodule // dac_sink

//--- test/tb_top.sv
// self-checking bench for the bunch drive generator
`timescale 1ns/1ns
module tb_top;
  import drive_gen_pkg::*;
  logic          ref_clk_i = 1'b0;
  logic          rst_b_i   = 1'b0;
  logic [7:0]    paddr_i   = 8'h00;
  logic          psel_i    = 1'b0;
  logic          penable_i = 1'b0;
  logic          pwrite_i  = 1'b0;
  logic [31:0]   pwdata_i  = 32'h0;
  logic          fid_i     = 1'b0;
  logic          stall     = 1'b0;
  logic [31:0]   prdata_o;
  logic          pready_o;
  logic          pslverr_o;
  drive_sample_t dac_o;
  logic          dac_valid_o;
  logic          dac_ready_i;
  logic [31:0]   rd;
  logic [31:0]   a0;
  logic          err;
  int            fails   = 0;
  int            checked = 0;

  bunch_drive_gen DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .fid_i(fid_i),
    .dac_o(dac_o), .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i));
  dac_sink sink (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .dac_i(dac_o),
    .dac_valid_i(dac_valid_o), .dac_ready_o(dac_ready_i), .stall_i(stall));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // setup, then hold everything until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 32'h0, 32'h1);
      finish_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  task automatic t_regs();
    rdchk("ctrl", CTRL_OFF, 32'h0);
    rdchk("last", LAST_OFF, 32'(LAST_RST));
    apb(1'b1, 8'h30, 32'hffff_ffff);
    chk("unmapped wr err", 32'(err), 32'h1);
    rdchk("unmapped rd", 8'h30, 32'h0);
    apb(1'b1, MASK_LO_OFF, 32'ha5a5_5a5a);
    apb(1'b1, MASK_HI_OFF, 32'h0f0f_f0f0);
    rdchk("mask lo", MASK_LO_OFF, 32'ha5a5_5a5a);
    rdchk("mask hi", MASK_HI_OFF, 32'h0f0f_f0f0);
    apb(1'b1, AMPL_OFF, 32'h0001_ffff);
    rdchk("ampl clamp", AMPL_OFF, 32'(AMPL_FULL));
  endtask

  task automatic t_sweep();
    apb(1'b1, CTRL_OFF, 32'h1);
    apb(1'b1, FREQ_OFF, 32'h0000_1000);
    apb(1'b1, SPAN_OFF, 32'h64);
    rdchk("period 0 span", ACT_SPAN_OFF, 32'h0);
    rdchk("freq in use", ACT_FREQ_OFF, 32'h1000);
    apb(1'b1, PERIOD_OFF, 32'h1);
    apb(1'b1, SPAN_OFF, 32'h0);
    rdchk("span 0 period", ACT_PERIOD_OFF, 32'h0);
    apb(1'b1, SPAN_OFF, 32'h3e8);
    rdchk("span cap", ACT_SPAN_OFF, 32'hfa);
    rdchk("act period", ACT_PERIOD_OFF, 32'h1);
    apb(1'b0, ACT_FREQ_OFF, 32'h0);
    a0 = rd;
    apb(1'b0, ACT_FREQ_OFF, 32'h0);
    chk("sweep low", 32'(a0 >= 32'h0e0c && rd <= 32'h11f4), 32'h1);
    chk("sweep moves", 32'(a0 != rd), 32'h1);
    apb(1'b1, CTRL_OFF, 32'h5);
    rdchk("dc no sweep", ACT_SPAN_OFF, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h0);
    apb(1'b1, SPAN_OFF, 32'h0);
  endtask

  task automatic run_drive(input logic [31:0] c, input logic [31:0] amp, input int pk);
    drive_sample_t      s;
    logic signed [15:0] v;
    apb(1'b1, AMPL_OFF, amp);
    sink.got_q.delete();
    apb(1'b1, CTRL_OFF, c);
    repeat (20) @(posedge ref_clk_i);
    apb(1'b1, CTRL_OFF, 32'h0);
    repeat (30) @(posedge ref_clk_i);
    chk("sample count", 32'(sink.got_q.size() > 8), 32'h1);
    for (int k = 0; k + 1 < sink.got_q.size(); k++) begin
      s = sink.got_q[k];
      // square sign follows phase, only its size is fixed
      v = (c[2:1] == 2'h1 && s.val < 0) ? -s.val : s.val;
      chk("bunch", 32'(sink.got_q[k + 1].bunch), 32'(s.bunch + 6'h1) & 32'h3);
      chk("val", 32'(v), (s.bunch[0] == 1'b0) ? 32'(pk) : 32'h0);
    end
  endtask

  task automatic t_drive();
    apb(1'b1, LAST_OFF, 32'h3);
    apb(1'b1, MASK_LO_OFF, 32'h5);
    // realign the slot count so the run starts inside 0..3
    fid_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    fid_i <= 1'b0;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("fid realign", 32'(rd[5:0]), 32'h0);
    run_drive(32'h5, 32'h10000, 32767);
    run_drive(32'h5, 32'h08000, 16383);
    run_drive(32'h5, 32'h00000, 0);
    run_drive(32'h3, 32'h10000, 32767);
    run_drive(32'h7, 32'h10000, 0);
  endtask

  // far side stalls until the buffer refuses, then drains it
  task automatic t_fifo();
    int n;
    stall <= 1'b1;
    apb(1'b1, CTRL_OFF, 32'h5);
    n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 100);
    chk("fifo full", 32'(rd[7]), 32'h1);
    apb(1'b1, CTRL_OFF, 32'h0);
    sink.got_q.delete();
    stall <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    chk("drained", 32'(sink.got_q.size()), 32'(FIFO_DEPTH + 1));
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("not full", 32'(rd[7:6]), 32'h0);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_sweep();
    t_drive();
    t_fifo();
    finish_test();
  end
endmodule // tb_top
